// >>> lwm_cfg.svh
// Timing and encoding constants for the low-side wake-up mask timer.
// Assumes a 25 MHz system clock; included by the package and the design.
`ifndef LWM_CFG_SVH
`define LWM_CFG_SVH

// System clock period in nanoseconds.
`define LWM_CLK_PERIOD_NS   40
// Long execution hold and normal comparator settling, in nanoseconds.
`define LWM_HOLD_SLOW_NS    150000
// Short execution hold and full-performance settling, in nanoseconds.
`define LWM_HOLD_FAST_NS    2000
// Oscillator overshoot window after deep sleep exit, in nanoseconds.
`define LWM_OVERSHOOT_NS    6000
// Main clock out-of-spec window under short hold, in nanoseconds.
`define LWM_MCLK_RISK_NS    4000
// Cycle counts derived from the times (least times round up).
`define LWM_HOLD_SLOW_CYC   ((`LWM_HOLD_SLOW_NS + `LWM_CLK_PERIOD_NS - 1) / `LWM_CLK_PERIOD_NS)
`define LWM_HOLD_FAST_CYC   ((`LWM_HOLD_FAST_NS + `LWM_CLK_PERIOD_NS - 1) / `LWM_CLK_PERIOD_NS)
`define LWM_OVERSHOOT_CYC   ((`LWM_OVERSHOOT_NS + `LWM_CLK_PERIOD_NS - 1) / `LWM_CLK_PERIOD_NS)
`define LWM_MCLK_RISK_CYC   ((`LWM_MCLK_RISK_NS + `LWM_CLK_PERIOD_NS - 1) / `LWM_CLK_PERIOD_NS)
// Oscillator frequency limits in MHz for core levels 0 to 3.
`define LWM_FLIM_L0         8'h04
`define LWM_FLIM_L1         8'h07
`define LWM_FLIM_L2         8'h0B
`define LWM_FLIM_L3         8'h0E
// Main clock divider encoding for divide-by-two.
`define LWM_DIV_BY_TWO      3'h1
// Counter width.
`define LWM_CNT_W           13

`endif

// >>> lwm_pkg.sv
// Types for the low-side wake-up mask timer.
// Assumes lwm_cfg.svh is on the include path.
`include "lwm_cfg.svh"

package lwm_pkg;

    // Low-side supervision settings as software sets them.
    typedef struct packed {
        logic       low_supervisor_enable;
        logic       low_monitor_enable;
        logic       low_supervisor_full_perf;
        logic       low_monitor_full_perf;
    } lwm_ctrl_type;

    // Settling phase.
    typedef enum logic [1:0] {
        LWM_IDLE,
        LWM_SETTLE,
        LWM_CHECK
    } lwm_settle_type;

    // All state of the timer.
    typedef struct packed {
        logic [`LWM_CNT_W-1:0] hold_cnt;
        logic [`LWM_CNT_W-1:0] osc_cnt;
        logic [`LWM_CNT_W-1:0] risk_cnt;
        logic [`LWM_CNT_W-1:0] settle_cnt;
        lwm_settle_type        settle_st;
        logic                  reset_req;
        logic [1:0]            wake_sync;
        logic [1:0]            good_sync;
        logic [1:0]            lvl_prev;
    } lwm_state_type;

endpackage

// >>> lwm_timer.sv
// Wake-up execution mask, comparator settling delay and core-level reset.
// Assumes all control inputs come from logic on sys_clk except the wake
// event and the core-voltage-good level, which arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none
`include "lwm_cfg.svh"

module lwm_timer (
    // Clock and reset.
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    // Low-side supervision control.
    input  wire lwm_pkg::lwm_ctrl_type ctrl,
    input  wire logic [1:0]           core_level,
    input  wire logic                 core_level_raise,
    input  wire logic                 core_good_async,
    // Clocking context.
    input  wire logic                 wake_deep_async,
    input  wire logic                 main_clk_from_osc,
    input  wire logic [7:0]           osc_freq_mhz,
    input  wire logic [2:0]           main_clock_divider,
    // Results.
    output logic                      cpu_hold,
    output logic                      osc_overshoot,
    output logic                      main_clk_at_risk,
    output logic                      sub_clk_gate,
    output logic                      settle_busy,
    output logic                      device_reset
);

    localparam logic [`LWM_CNT_W-1:0] SLOW = `LWM_CNT_W'(`LWM_HOLD_SLOW_CYC);
    localparam logic [`LWM_CNT_W-1:0] FAST = `LWM_CNT_W'(`LWM_HOLD_FAST_CYC);
    localparam logic [`LWM_CNT_W-1:0] OVSH = `LWM_CNT_W'(`LWM_OVERSHOOT_CYC);
    localparam logic [`LWM_CNT_W-1:0] RISK = `LWM_CNT_W'(`LWM_MCLK_RISK_CYC);

    lwm_pkg::lwm_state_type st_r;
    lwm_pkg::lwm_state_type st_nxt;
    logic                   wake_pulse;
    logic                   fast_mode;
    logic                   over_limit;

    // Counts a down counter one step toward zero.
    function automatic logic [`LWM_CNT_W-1:0] dec_sat(input logic [`LWM_CNT_W-1:0] v);
        dec_sat = (v == '0) ? v : v - `LWM_CNT_W'(1);
    endfunction

    // Returns the oscillator limit for a core level.
    function automatic logic [7:0] freq_limit(input logic [1:0] lvl);
        unique case (lvl)
            2'h0: freq_limit = `LWM_FLIM_L0;
            2'h1: freq_limit = `LWM_FLIM_L1;
            2'h2: freq_limit = `LWM_FLIM_L2;
            2'h3: freq_limit = `LWM_FLIM_L3;
        endcase
    endfunction

    // Short mask when both are off or both at full performance.
    assign fast_mode = (!ctrl.low_supervisor_enable && !ctrl.low_monitor_enable) ||
                       (ctrl.low_supervisor_full_perf && ctrl.low_monitor_full_perf);
    // Main clock is exposed when taken from the oscillator at any divider but two, above the limit.
    assign over_limit = main_clk_from_osc && (main_clock_divider != `LWM_DIV_BY_TWO) &&
                        (osc_freq_mhz > freq_limit(core_level));
    // A wake event is the rising edge of the synchronised level.
    assign wake_pulse = st_r.wake_sync[1] && !st_r.lvl_prev[0];

    // Next-state logic for the whole timer.
    always_comb begin
        st_nxt = st_r;
        // Two-flop synchronisers; only the second stage feeds any logic.
        st_nxt.wake_sync = {st_r.wake_sync[0], wake_deep_async};
        st_nxt.good_sync = {st_r.good_sync[0], core_good_async};
        st_nxt.lvl_prev  = {1'b0, st_r.wake_sync[1]};
        // Counters stop at zero, so an idle counter can never wrap into a hold.
        st_nxt.hold_cnt  = dec_sat(st_r.hold_cnt);
        st_nxt.osc_cnt   = dec_sat(st_r.osc_cnt);
        st_nxt.risk_cnt  = dec_sat(st_r.risk_cnt);
        st_nxt.reset_req = 1'b0;
        if (wake_pulse) begin
            st_nxt.hold_cnt = fast_mode ? FAST : SLOW;
            st_nxt.osc_cnt  = OVSH;
            // The risk count spans the short hold plus the exposed time after it.
            st_nxt.risk_cnt = (fast_mode && over_limit) ? FAST + RISK : '0;
        end
        unique case (st_r.settle_st)
            lwm_pkg::LWM_IDLE: begin
                if (core_level_raise) begin
                    st_nxt.settle_cnt = ctrl.low_supervisor_full_perf ? FAST : SLOW;
                    st_nxt.settle_st  = lwm_pkg::LWM_SETTLE;
                end
            end
            lwm_pkg::LWM_SETTLE: begin
                st_nxt.settle_cnt = dec_sat(st_r.settle_cnt);
                if (st_r.settle_cnt == `LWM_CNT_W'(1)) begin
                    st_nxt.settle_st = lwm_pkg::LWM_CHECK;
                end
            end
            lwm_pkg::LWM_CHECK: begin
                // Only an enabled supervisor may pull the device into reset.
                st_nxt.reset_req = ctrl.low_supervisor_enable && !st_r.good_sync[1];
                st_nxt.settle_st = lwm_pkg::LWM_IDLE;
            end
            default: st_nxt.settle_st = lwm_pkg::LWM_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come from the state flip-flops, except sub_clk_gate, which is tied low.
    assign cpu_hold         = (st_r.hold_cnt != '0);
    assign osc_overshoot    = (st_r.osc_cnt != '0);
    assign main_clk_at_risk = (st_r.risk_cnt != '0) && (st_r.hold_cnt == '0);
    assign sub_clk_gate     = 1'b0;
    assign settle_busy      = (st_r.settle_st != lwm_pkg::LWM_IDLE);
    assign device_reset     = st_r.reset_req;

    // Normal mode wake holds the CPU for the full long count.
    a_slow_hold_len: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wake_pulse && !fast_mode |=> st_r.hold_cnt == SLOW)
        else $error("long hold not loaded");

    // Fast mode wake loads only the short count.
    a_fast_hold_len: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wake_pulse && fast_mode |=> st_r.hold_cnt == FAST)
        else $error("short hold not loaded");

    // The overshoot flag rises with the wake and stays up for at least 8 cycles.
    a_overshoot_win: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wake_pulse |=> osc_overshoot [*8])
        else $error("overshoot window short");

    // A short-hold wake with the main clock above its level limit.
    sequence s_fast_risky_wake;
        wake_pulse && fast_mode && over_limit;
    endsequence

    a_risk_after_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_fast_risky_wake |=> ##50 main_clk_at_risk)
        else $error("risk window missing");

    // The sub-system clock is never held back.
    a_sub_clk_free: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !sub_clk_gate)
        else $error("sub clock gated");

    // Full-performance raise starts the short settling delay.
    a_fast_settle: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r.settle_st == lwm_pkg::LWM_IDLE && core_level_raise &&
        ctrl.low_supervisor_full_perf |=> st_r.settle_cnt == FAST ##50 settle_busy)
        else $error("fast settle wrong");

    // Normal mode raise starts the long settling delay.
    a_slow_settle: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r.settle_st == lwm_pkg::LWM_IDLE && core_level_raise &&
        !ctrl.low_supervisor_full_perf |=> st_r.settle_cnt == SLOW)
        else $error("slow settle wrong");

    // A reset only follows a failed check of the core level.
    a_reset_cause: assert property (@(posedge sys_clk) disable iff (!arst_n)
        device_reset |-> $past(st_r.settle_st) == lwm_pkg::LWM_CHECK && !$past(st_r.good_sync[1]))
        else $error("spurious reset");

    // The hold drops as soon as its counter reaches zero.
    a_hold_release: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cpu_hold && !wake_pulse && st_r.hold_cnt == `LWM_CNT_W'(1) |=> !cpu_hold)
        else $error("hold not released");

    // A raise while a delay runs must not restart it.
    a_raise_ignored: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r.settle_st == lwm_pkg::LWM_SETTLE && st_r.settle_cnt > `LWM_CNT_W'(1) |=>
        st_r.settle_st == lwm_pkg::LWM_SETTLE &&
        st_r.settle_cnt == $past(st_r.settle_cnt) - `LWM_CNT_W'(1))
        else $error("settle delay restarted");

    // Last count of a settling delay.
    sequence s_settle_last;
        st_r.settle_st == lwm_pkg::LWM_SETTLE && st_r.settle_cnt == `LWM_CNT_W'(1);
    endsequence

    // One check cycle, then back to idle.
    sequence s_check_then_idle;
        st_r.settle_st == lwm_pkg::LWM_CHECK ##1 st_r.settle_st == lwm_pkg::LWM_IDLE;
    endsequence

    a_settle_check: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_settle_last |=> s_check_then_idle)
        else $error("settle check step missing");

    // A reset request lasts one cycle and needs the supervisor on.
    a_reset_pulse: assert property (@(posedge sys_clk) disable iff (!arst_n)
        device_reset |-> $past(ctrl.low_supervisor_enable) ##1 !device_reset)
        else $error("reset pulse wrong");

    // The overshoot window ends when its count runs out.
    a_overshoot_end: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r.osc_cnt == `LWM_CNT_W'(1) && !wake_pulse |=> !osc_overshoot)
        else $error("overshoot window long");

    // A wake with no hazard clears any risk window at once.
    a_no_risk_safe: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wake_pulse && !(fast_mode && over_limit) |=> !main_clk_at_risk)
        else $error("risk flagged without hazard");

    // The risk window closes when its count runs out.
    a_risk_end: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r.risk_cnt == `LWM_CNT_W'(1) && !wake_pulse |=> !main_clk_at_risk)
        else $error("risk window long");

endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the low-side wake-up mask timer.
// Assumes lwm_pkg and lwm_timer are compiled first; assertions live in the design.
`timescale 1ns/1ns
`default_nettype none
module tb;
    // Clock, reset and stimulus.
    logic                  sys_clk = 1'b0;
    logic                  arst_n = 1'b0;
    lwm_pkg::lwm_ctrl_type ctrl = '0;
    logic [1:0]            core_level = 2'h0;
    logic                  core_level_raise = 1'b0;
    logic                  core_good_async = 1'b1;
    logic                  wake_deep_async = 1'b0;
    logic                  main_clk_from_osc = 1'b1;
    logic [7:0]            osc_freq_mhz = 8'h10;
    logic [2:0]            main_clock_divider = 3'h0;
    wire logic [5:0]       outs;
    int                    fail_count = 0;
    int                    tests_run = 0;
    int                    cyc = 0;
    int                    lim_q[$] = '{4, 7, 11, 14};
    int                    wait_q[$] = '{32, 48, 80, 100};

    // The clock toggles every half period of 40 ns.
    always #20 sys_clk = ~sys_clk;

    lwm_timer DUT (.sys_clk(sys_clk), .arst_n(arst_n), .ctrl(ctrl), .core_level(core_level),
        .core_level_raise(core_level_raise), .core_good_async(core_good_async),
        .wake_deep_async(wake_deep_async), .main_clk_from_osc(main_clk_from_osc),
        .osc_freq_mhz(osc_freq_mhz), .main_clock_divider(main_clock_divider),
        .cpu_hold(outs[0]), .osc_overshoot(outs[1]), .main_clk_at_risk(outs[2]),
        .sub_clk_gate(outs[3]), .settle_busy(outs[4]), .device_reset(outs[5]));

    // Compares one value with its expectation and counts the result.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Counts cycles until an output rises, then how long it stays high.
    task automatic meas(input int idx, input int lim, output int dly, output int len);
        int n;
        n = 0;
        len = 0;
        while (n < lim && outs[idx] !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        dly = n;
        while (n < lim && outs[idx] === 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
            len++;
        end
    endtask

    // Wakes the device and measures hold, overshoot and risk windows.
    task automatic wake(input int hold, input bit haz);
        int hd, hl, od, ol, rd, rl;
        wake_deep_async = 1'b1;
        fork
            meas(0, 4000, hd, hl);
            meas(1, 4000, od, ol);
            meas(2, 4000, rd, rl);
        join
        check(hd, 3);
        check(hl, hold);
        check(ol, 150);
        check(rl, haz ? 100 : 0);
        check(haz ? rd : 0, haz ? 3 + hold : 0);
        check(outs[3], 1'b0);
        wake_deep_async = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        $display("Wake test done, hold %0d", hold);
    endtask

    // Starts a settling delay, with a second raise that must be ignored.
    task automatic settle(input bit fp, input bit good, input int n);
        int bd, bl, rd, rl, xd, xl;
        ctrl = '{1'b1, 1'b1, fp, fp};
        core_good_async = good;
        repeat (4) @(posedge sys_clk);
        #1;
        core_level_raise = 1'b1;
        @(posedge sys_clk);
        #1;
        core_level_raise = 1'b0;
        fork
            meas(4, n + 20, bd, bl);
            meas(5, n + 20, rd, rl);
            begin
                repeat (10) @(posedge sys_clk);
                #1;
                core_level_raise = 1'b1;
                @(posedge sys_clk);
                #1;
                core_level_raise = 1'b0;
            end
        join
        check(bd, 0);
        check(bl, n + 1);
        check(rl, good ? 0 : 1);
        meas(4, 60, xd, xl);
        check(xl, 0);
        $display("Settle test done, delay %0d", n);
    endtask

    // Ends a hung run with a counted mismatch.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            give_verdict();
        end
    end

    // Main sequence.
    initial begin
        int lv;
        void'($urandom(23490));
        repeat (8) @(posedge sys_clk);
        #1;
        check(outs, 6'h00);
        arst_n = 1'b1;
        @(posedge sys_clk);
        #1;
        for (int i = 0; i < 4; i++) begin
            lv = $urandom % 4;
            core_level = lv[1:0];
            // The last pass sits exactly on the limit, which is not above it.
            osc_freq_mhz = 8'(lim_q[lv] + ((i == 3) ? 0 : 1 + $urandom % 40));
            main_clock_divider = (i == 2) ? 3'h1 : 3'(2 + $urandom % 6);
            ctrl = (i == 0) ? '0 : '1;
            wake(50, i < 2);
            if (i == 2) begin
                repeat (wait_q[lv]) @(posedge sys_clk);
                #1;
                main_clock_divider = 3'h0;
            end
        end
        ctrl = '{1'b1, 1'b1, 1'b0, 1'b0};
        main_clock_divider = 3'h0;
        wake(3750, 1'b0);
        settle(1'b1, 1'b0, 50);
        settle(1'b0, 1'b1, 3750);
        give_verdict();
    end
endmodule
`default_nettype wire
